// *** core/abrg_core.sv ***
`timescale 1ns/100ps
`include "abrg_defines.svh"

module abrg_core
	import abrg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        rx_pin,
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [7:0]  rx_data,
	output logic      [7:0]  rdata,
	output logic             baud_tick,
	output logic             rx_hold_idle,
	output logic             receive_flag,
	output logic             irq
);

	logic           rx_level;
	abrg_state_type state_q;
	abrg_state_type state_d;
	logic [15:0]    div_q;
	logic [15:0]    div_d;
	logic [9:0]     pre_q;
	logic [9:0]     pre_d;
	logic [15:0]    tmr_q;
	logic [15:0]    tmr_d;
	logic           tick_q;
	logic           tick_d;
	logic [2:0]     edges_q;
	logic [2:0]     edges_d;
	logic           rx_prev_q;
	logic           autobaud_enable_q;
	logic           autobaud_enable_d;
	logic           wue_q;
	logic           wue_d;
	logic           wide_q;
	logic           wide_d;
	logic           hspeed_q;
	logic           hspeed_d;
	logic           sync_q;
	logic           sync_d;
	logic           ovf_q;
	logic           ovf_d;
	logic           rcf_q;
	logic           rcf_d;
	logic [1:0]     ist_q;
	logic [1:0]     ist_d;
	logic [1:0]     ien_q;
	logic [1:0]     ien_d;
	logic [7:0]     rdata_q;
	logic [7:0]     rdata_d;
	logic           rise;
	logic           fall;
	logic           calib;
	logic [9:0]     base_pre;
	logic [9:0]     abd_pre;
	logic [9:0]     pre_top;
	logic           pre_wrap;
	logic           div_wr;
	logic           done_ev;
	logic           ovf_ev;

	abrg_sync u_rx_sync
	(
		.clk    (clk),
		.resetn (resetn),
		.pin_in (rx_pin),
		.level  (rx_level)
	);

	assign rise  = rx_level & ~rx_prev_q;
	assign fall  = ~rx_level & rx_prev_q;
	assign calib = (state_q != ABRG_IDLE);

	// prescale select: sync mode counts as high speed, wide alone equals high alone
	always_comb
	begin
		if ((hspeed_q | sync_q) & wide_q)
		begin
			base_pre = `ABRG_PRE_4; // see R12
			abd_pre  = `ABRG_PRE_32; // see R9
		end
		else if (hspeed_q | wide_q | sync_q)
		begin
			base_pre = `ABRG_PRE_16; // see R11
			abd_pre  = `ABRG_PRE_128; // see R9
		end
		else
		begin
			base_pre = `ABRG_PRE_64; // see R10
			abd_pre  = `ABRG_PRE_512; // see R9
		end
		pre_top = (state_q == ABRG_COUNT) ? abd_pre : base_pre; // see R8
	end

	assign pre_wrap = (pre_q == pre_top);
	assign div_wr   = wr & ((addr == `ABRG_ADDR_DIV_LO) | (addr == `ABRG_ADDR_DIV_HI));

	// calibration sequence
	always_comb
	begin
		state_d = state_q;
		edges_d = edges_q;
		done_ev = 1'b0;
		ovf_ev  = 1'b0;
		unique case (state_q)
			ABRG_IDLE:
			begin
				edges_d = 3'h0;
				if (autobaud_enable_q)
					state_d = wue_q ? ABRG_BREAK : ABRG_START; // see R1
			end
			ABRG_BREAK:
				if (rise)
					state_d = ABRG_START; // see R13
			ABRG_START:
				if (rise)
				begin
					state_d = ABRG_COUNT; // see R3
					edges_d = 3'h1;
				end
			ABRG_COUNT:
			begin
				if (rise)
					edges_d = edges_q + 3'h1;
				// an abandoned run must not complete on a late fifth edge
				if (rise && edges_q == `ABRG_EDGES - 3'h1 && autobaud_enable_q)
				begin
					state_d = ABRG_DONE; // see R2 R4
					done_ev = 1'b1;
				end
				if (pre_wrap && div_q == 16'hffff && !sync_q)
					ovf_ev = 1'b1; // see R18
			end
			ABRG_DONE:
				state_d = ABRG_IDLE;
			default:
				state_d = ABRG_IDLE;
		endcase
		if (!autobaud_enable_q && state_q != ABRG_DONE)
			state_d = ABRG_IDLE; // see R19
	end

	// prescaler, divisor counter and generator timer
	always_comb
	begin
		pre_d  = pre_wrap ? 10'h000 : pre_q + 10'h001;
		div_d  = div_q;
		tmr_d  = tmr_q;
		tick_d = 1'b0;
		if (state_q == ABRG_START)
			div_d = 16'h0001; // see R14
		else if (state_q == ABRG_COUNT)
		begin
			if (pre_wrap)
				div_d = div_q + 16'h0001; // see R7
		end
		else if (pre_wrap)
		begin
			if (tmr_q >= (wide_q ? div_q : {8'h00, div_q[7:0]}))
			begin
				tmr_d  = 16'h0000; // see R16
				tick_d = 1'b1;
			end
			else
				tmr_d = tmr_q + 16'h0001;
		end
		if (rise && state_q == ABRG_START)
			pre_d = 10'h000;
		if (div_wr && !calib)
		begin
			pre_d = 10'h000; // see R17
			tmr_d = 16'h0000;
			if (addr == `ABRG_ADDR_DIV_LO)
				div_d[7:0] = wdata;
			else
				div_d[15:8] = wdata;
		end
	end

	// control bits, flags and read data
	always_comb
	begin
		autobaud_enable_d  = autobaud_enable_q;
		wue_d    = wue_q;
		wide_d   = wide_q;
		hspeed_d = hspeed_q;
		sync_d   = sync_q;
		ovf_d    = ovf_q;
		rcf_d    = rcf_q;
		ien_d    = ien_q;
		ist_d    = ist_q;
		rdata_d  = 8'h00;
		if (wr && addr == `ABRG_ADDR_CTRL)
		begin
			autobaud_enable_d  = wdata[`ABRG_CTRL_AUTOBAUD_ENABLE];
			wue_d    = wdata[`ABRG_CTRL_WUE];
			wide_d   = wdata[`ABRG_CTRL_WIDE];
			hspeed_d = wdata[`ABRG_CTRL_HSPEED];
			sync_d   = wdata[`ABRG_CTRL_SYNC];
			if (wdata[`ABRG_CTRL_AUTOBAUD_ENABLE] && !autobaud_enable_q)
				ovf_d = 1'b0;
		end
		if (wr && addr == `ABRG_ADDR_IRQ_EN)
			ien_d = wdata[1:0];
		if (wr && addr == `ABRG_ADDR_IRQ_CLR)
			ist_d = ist_q & ~wdata[1:0];
		if (rd && addr == `ABRG_ADDR_RXBUF)
			rcf_d = 1'b0; // see R5
		// wake bit drops once the break ends
		if (state_q == ABRG_BREAK && rise)
			wue_d = 1'b0;
		// hardware sets win over software clears
		if (done_ev)
		begin
			autobaud_enable_d = 1'b0; // see R4
			rcf_d   = 1'b1;
			ist_d[`ABRG_IRQ_DONE] = 1'b1;
		end
		if (ovf_ev)
		begin
			ovf_d = 1'b1; // see R18
			ist_d[`ABRG_IRQ_OVF] = 1'b1;
		end
		if (rd)
		begin
			unique case (addr)
				`ABRG_ADDR_DIV_LO:   rdata_d = div_q[7:0];
				`ABRG_ADDR_DIV_HI:   rdata_d = div_q[15:8]; // see R6
				`ABRG_ADDR_CTRL:     rdata_d = {ovf_q, calib, 1'b0, hspeed_q, wide_q,
					1'b0, wue_q, autobaud_enable_q} | {2'b00, sync_q, 5'h00};
				`ABRG_ADDR_RXBUF:    rdata_d = rx_data;
				`ABRG_ADDR_IRQ_STAT: rdata_d = {6'h00, ist_q};
				`ABRG_ADDR_IRQ_EN:   rdata_d = {6'h00, ien_q};
				default:             rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q   <= ABRG_IDLE;
			edges_q   <= 3'h0;
			div_q     <= 16'h0000;
			pre_q     <= 10'h000;
			tmr_q     <= 16'h0000;
			tick_q    <= 1'b0;
			rx_prev_q <= 1'b1;
			autobaud_enable_q   <= 1'b0;
			wue_q     <= 1'b0;
			wide_q    <= 1'b0;
			hspeed_q  <= 1'b0;
			sync_q    <= 1'b0;
			ovf_q     <= 1'b0;
			rcf_q     <= 1'b0;
			ist_q     <= 2'h0;
			ien_q     <= 2'h0;
			rdata_q   <= 8'h00;
		end
		else
		begin
			state_q   <= state_d;
			edges_q   <= edges_d;
			div_q     <= div_d;
			pre_q     <= pre_d;
			tmr_q     <= tmr_d;
			tick_q    <= tick_d;
			rx_prev_q <= rx_level;
			autobaud_enable_q   <= autobaud_enable_d;
			wue_q     <= wue_d;
			wide_q    <= wide_d;
			hspeed_q  <= hspeed_d;
			sync_q    <= sync_d;
			ovf_q     <= ovf_d;
			rcf_q     <= rcf_d;
			ist_q     <= ist_d;
			ien_q     <= ien_d;
			rdata_q   <= rdata_d;
		end
	end

	assign rdata        = rdata_q;
	assign baud_tick    = tick_q;
	assign rx_hold_idle = calib | autobaud_enable_q; // see R1
	assign receive_flag = rcf_q;
	assign irq          = |(ist_q & ien_q);

	// assertions
	sequence fifth_rise_s;
		state_q == ABRG_COUNT && rise && edges_q == 3'h4 && autobaud_enable_q;
	endsequence

	done_clears_en_a: assert property (@(posedge clk) disable iff (!resetn) // see R4
		fifth_rise_s |=> (!autobaud_enable_q && rcf_q) ##1 (state_q == ABRG_IDLE))
		else $error("calibration end did not clear enable or set flag");

	hold_idle_a: assert property (@(posedge clk) disable iff (!resetn) // see R1
		(state_q == ABRG_IDLE && autobaud_enable_q) |=> (calib && rx_hold_idle))
		else $error("calibration did not start or receiver not held idle");

	count_start_a: assert property (@(posedge clk) disable iff (!resetn) // see R3
		(state_q == ABRG_START && rise && autobaud_enable_q) |=> (state_q == ABRG_COUNT && div_q == 16'h0001))
		else $error("counter did not start at one on first rise");

	count_step_a: assert property (@(posedge clk) disable iff (!resetn) // see R7
		(state_q == ABRG_COUNT && pre_wrap && !div_wr) |=> (div_q == $past(div_q) + 16'h0001))
		else $error("calibration counter did not step");

	abd_rate_a: assert property (@(posedge clk) disable iff (!resetn) // see R8
		(state_q == ABRG_COUNT && !hspeed_q && !wide_q && !sync_q) |-> pre_top == 10'h1ff)
		else $error("calibration prescale wrong");

	base_rate_a: assert property (@(posedge clk) disable iff (!resetn) // see R10
		(!calib && !hspeed_q && !wide_q && !sync_q) |-> pre_top == 10'h03f)
		else $error("base prescale wrong");

	one_select_a: assert property (@(posedge clk) disable iff (!resetn) // see R11
		(!calib && !sync_q && (hspeed_q ^ wide_q)) |-> pre_top == 10'h00f)
		else $error("single select prescale wrong");

	wide_sync_a: assert property (@(posedge clk) disable iff (!resetn) // see R12
		(!calib && sync_q && wide_q) |-> pre_top == 10'h003)
		else $error("sync wide prescale wrong");

	div_reset_a: assert property (@(posedge clk) disable iff (!resetn) // see R17
		(div_wr && !calib) |=> (tmr_q == 16'h0000 && pre_q == 10'h000))
		else $error("divisor write did not reset timer");

	abandon_a: assert property (@(posedge clk) disable iff (!resetn) // see R19
		(state_q == ABRG_COUNT && !autobaud_enable_q) |=> (state_q == ABRG_IDLE && !$rose(rcf_q)))
		else $error("abandoned calibration misbehaved");

	wake_wait_a: assert property (@(posedge clk) disable iff (!resetn) // see R13
		(state_q == ABRG_BREAK && !rise && autobaud_enable_q) |=> state_q == ABRG_BREAK)
		else $error("calibration began during break");

endmodule : abrg_core

// *** core/abrg_defines.svh ***
// Operation
// R1 - setting autobaud enable starts calibration and holds the receiver idle until done
// R2 - calibration measures a 55h sync character with five rising edges
// R3 - counter starts at first rising edge after the start bit
// R4 - fifth rising edge stops count, clears enable, sets receive flag
// R5 - software reads receive buffer to clear receive flag, discarding the value
// R6 - software checks high divisor byte is zero for low-byte modes
// R7 - both divisor bytes form one 16-bit counter during calibration
// R8 - calibration counter runs at one eighth of the base clock
// R9 - selects pick base and calibration prescale: 64/512, 16/128, 4/32
// R10 - async, both selects clear: divide by 64 per divisor step
// R11 - only one select set: divide by 16 per divisor step
// R12 - sync wide divisor uses divide by 4 like async high-speed wide
// R13 - with wake enable, calibrate on the character after the break
// R14 - counter starts at one; software subtracts one afterwards
// R15 - software keeps incoming rate within the measurable range
// R16 - bit rate is prescaled clock over divisor plus one
// R17 - any divisor write resets the generator timer at once; writes during calibration are ignored and leave the timer as it is
// R18 - async calibration overflow sets the overflow flag
// R19 - clearing enable early abandons calibration without setting receive flag
`ifndef ABRG_DEFINES_SVH
`define ABRG_DEFINES_SVH

// register offsets
`define ABRG_ADDR_DIV_LO   4'h0
`define ABRG_ADDR_DIV_HI   4'h1
`define ABRG_ADDR_CTRL     4'h2
`define ABRG_ADDR_RXBUF    4'h3
`define ABRG_ADDR_IRQ_STAT 4'h4
`define ABRG_ADDR_IRQ_EN   4'h5
`define ABRG_ADDR_IRQ_CLR  4'h6

// control register fields
`define ABRG_CTRL_AUTOBAUD_ENABLE    0
`define ABRG_CTRL_WUE      1
`define ABRG_CTRL_WIDE     3
`define ABRG_CTRL_HSPEED   4
`define ABRG_CTRL_SYNC     5
`define ABRG_CTRL_OVF      7
`define ABRG_CTRL_BUSY     6

// interrupt status fields
`define ABRG_IRQ_DONE      0
`define ABRG_IRQ_OVF       1

// prescale counts in system clocks
`define ABRG_PRE_64        10'h03f
`define ABRG_PRE_16        10'h00f
`define ABRG_PRE_4         10'h003
`define ABRG_PRE_512       10'h1ff
`define ABRG_PRE_128       10'h07f
`define ABRG_PRE_32        10'h01f

`define ABRG_SYNC_CHAR     8'h55
`define ABRG_EDGES         3'h5

`endif

// *** core/abrg_pkg.sv ***
package abrg_pkg;

	// calibration sequence states, gray from idle through break, start and count to done
	typedef enum logic [2:0]
	{
		ABRG_IDLE  = 3'b000,
		ABRG_BREAK = 3'b001,
		ABRG_START = 3'b011,
		ABRG_COUNT = 3'b010,
		ABRG_DONE  = 3'b110
	} abrg_state_type;

endpackage : abrg_pkg

// *** core/abrg_sync.sv ***
`timescale 1ns/100ps
`include "abrg_defines.svh"

// three-stage input synchroniser; change accepted when stages two and three agree
module abrg_sync
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin_in,
	output logic      level
);

	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	// line idles high, so reset to one
	always_comb
	begin
		stage_d = {stage_q[1:0], pin_in};
		level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			stage_q <= 3'h7;
			level_q <= 1'b1;
		end
		else
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;

endmodule : abrg_sync

// *** sim/abrg_node.sv ***
`timescale 1ns/100ps

// remote node: optional break, then one sync character
module abrg_node
(
	input  wire logic clk,
	output logic      rx_pin
);
	// line idles high, driven to one from time zero
	initial rx_pin = 1'b1;

	// lsb first, start low, stop high; bit time given in clocks
	task automatic send(input int bit_clk, input bit brk);
		logic [9:0] frame;
		frame = {1'b1, 8'h55, 1'b0};
		if (brk)
		begin
			rx_pin <= 1'b0;
			repeat (13 * bit_clk) @(posedge clk);
			rx_pin <= 1'b1;
			repeat (2 * bit_clk) @(posedge clk);
		end
		for (int i = 0; i < 10; i++)
		begin
			rx_pin <= frame[i];
			repeat (bit_clk) @(posedge clk);
		end
	endtask : send
endmodule : abrg_node

// *** sim/tb_baud_generator_autobaud.sv ***
`timescale 1ns/100ps
`include "abrg_defines.svh"

module tb_baud_generator_autobaud;
	logic        clk, resetn, rx_pin, wr, rd, baud_tick, rx_hold_idle, receive_flag, irq;
	logic [3:0]  addr;
	logic [7:0]  wdata, rx_data, rdata, v, lo;
	logic [15:0] d16;
	logic [31:0] seed;
	int          bad_count, checks_done, n;
	int          exp_q[$];
	int          mode_c[5] = '{8'h00, 8'h10, 8'h08, 8'h18, 8'h28};
	int          mode_p[5] = '{64, 16, 16, 4, 4};

	abrg_core DUT
	(
		.clk(clk), .resetn(resetn), .rx_pin(rx_pin), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rx_data(rx_data), .rdata(rdata), .baud_tick(baud_tick),
		.rx_hold_idle(rx_hold_idle), .receive_flag(receive_flag), .irq(irq)
	);
	abrg_node node (.clk(clk), .rx_pin(rx_pin));

	// free-running system clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// clocks between two ticks, bounded wait
	task automatic gap(output int g);
		int t;
		t = 0;
		do
		begin
			@(posedge clk);
			#1 t++;
		end
		while (baud_tick !== 1'b1 && t < 5000);
		g = 0;
		do
		begin
			@(posedge clk);
			#1 g++;
		end
		while (baud_tick !== 1'b1 && g < 5000);
	endtask : gap

	// one calibration run; model: count = 1 + 8 bit times / calibration prescale
	task automatic ab(input logic [7:0] c, input int b, input bit brk, input bit abort);
		int e;
		e = 1 + 8 * b / ((c[3] && c[4]) ? 32 : (c[3] || c[4]) ? 128 : 512);
		rx_data <= 8'(xs());
		wr_reg(`ABRG_ADDR_IRQ_EN, 8'h01);
		wr_reg(`ABRG_ADDR_CTRL, c | 8'h01);
		// an abort lands mid-count, three bit times into the frame
		fork
			node.send(b, brk);
			begin
				#1 chk("hold", rx_hold_idle, 1);
				if (abort)
				begin
					repeat (3 * b) @(posedge clk);
					wr_reg(`ABRG_ADDR_CTRL, c);
					repeat (2) @(posedge clk);
					#1 chk("hold_off", rx_hold_idle, 0);
				end
			end
		join
		repeat (20) @(posedge clk);
		#1 chk("flag", receive_flag, !abort);
		chk("irq", irq, !abort);
		rd_reg(`ABRG_ADDR_CTRL, v);
		chk("ctrl", {v[7], v[0]}, 0);
		rd_reg(`ABRG_ADDR_DIV_LO, d16[7:0]);
		rd_reg(`ABRG_ADDR_DIV_HI, d16[15:8]);
		if (!abort)
		begin
			chk("div", (d16 + 1 >= e && d16 <= e + 1), 1);
			chk("div_hi_zero", d16[15:8] == 8'h00, e < 256);
		end
		wr_reg(`ABRG_ADDR_IRQ_EN, 8'h00);
		#1 chk("masked", irq, 0);
		rd_reg(`ABRG_ADDR_IRQ_STAT, v);
		chk("stat", v[0], !abort);
		rd_reg(`ABRG_ADDR_RXBUF, v);
		chk("rxbuf", v, rx_data);
		chk("flag_clr", receive_flag, 0);
		wr_reg(`ABRG_ADDR_IRQ_CLR, 8'h03);
		rd_reg(`ABRG_ADDR_IRQ_STAT, v);
		chk("stat_clr", v, 0);
		$display("test calibration ctrl %h done", c);
	endtask : ab

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// hang guard, well above the longest frame sequence
	initial
	begin
		#900000;
		bad_count++;
		wrap_up();
	end

	initial
	begin
		seed = 71;
		resetn = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		rx_data = 8'h00;
		bad_count = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(`ABRG_ADDR_DIV_LO, v);
		chk("div_lo_rst", v, 0);
		rd_reg(`ABRG_ADDR_CTRL, v);
		chk("ctrl_rst", v, 0);
		chk("irq_rst", irq, 0);
		$display("test reset done");
		// high byte is random in byte modes, where it must be ignored
		for (int m = 0; m < 5; m++)
		begin
			lo = xs() % 8;
			wr_reg(`ABRG_ADDR_DIV_LO, lo);
			wr_reg(`ABRG_ADDR_DIV_HI, mode_c[m][3] ? 8'h00 : xs());
			wr_reg(`ABRG_ADDR_CTRL, mode_c[m]);
			exp_q.push_back(mode_p[m] * (lo + 1));
			gap(n);
			chk("tick_gap", n, exp_q.pop_front());
		end
		$display("test prescale done");
		ab(8'h00, 512, 0, 0);
		ab(8'h10, 4096, 0, 0);
		ab(8'h1a, 64, 1, 0);
		ab(8'h18, 64, 0, 1);
		wrap_up();
	end
endmodule : tb_baud_generator_autobaud
